// ### hdl/fcs_pkg.sv
// constants shared by the clock source configuration block
// assumes a single 10 MHz clock and an apb master on the register side
// Operation
// R1 - bus clock divides source by 1,2,4,8
// R2 - band bit requests high or low range
// R3 - gain bit picks high gain or low power
// R4 - low power disables bypassed fll unless debugging
// R5 - source bit requests crystal or external clock
// R6 - reference clock output toggles only when enabled
// R7 - stop keeps reference only if enabled before
// R8 - coarse trim loads factory or 0x80 at reset
// R9 - larger coarse trim lengthens reference period
// R10 - fine trim loads factory or zero at reset
// R11 - fine trim set lengthens period one step
// R12 - band status follows select after synchronisation
// R13 - reserved band code write is ignored
// R14 - band codes low, mid, high; locked by low power
// R15 - default range uses factors 512, 1024, 1536
// R16 - max option uses factors 608, 1216, 1824
// R17 - reference status follows select after synchronisation
// R18 - mode status follows source select after synchronisation
// R19 - ready flag sets after oscillator start-up
// R20 - ready flag clears when enable or source cleared; code keeps it set if only enable clears in external mode after start-up
// R21 - source codes fll, internal, external; 11 means 00
// R22 - status fields pass a two-stage synchroniser; code synchronises band, reference and mode only
package fcs_pkg;
  // byte addresses of the registers
  localparam logic [7:0] FCS_ADDR_DIV_OSC = 8'h00;
  localparam logic [7:0] FCS_ADDR_TRIM = 8'h04;
  localparam logic [7:0] FCS_ADDR_STATUS = 8'h08;
  localparam logic [7:0] FCS_ADDR_SOURCE = 8'h0c;
  // field positions in the divider / oscillator register
  localparam int FCS_DIV_LSB = 6;
  localparam int FCS_BAND_BIT = 5;
  localparam int FCS_GAIN_BIT = 4;
  localparam int FCS_LP_BIT = 3;
  localparam int FCS_EREF_SEL_BIT = 2;
  localparam int FCS_EREF_EN_BIT = 1;
  localparam int FCS_EREF_STOP_BIT = 0;
  // field positions in the status / range register
  localparam int FCS_BAND_LSB = 6;
  localparam int FCS_DMX_BIT = 5;
  localparam int FCS_REFST_BIT = 4;
  localparam int FCS_MODE_LSB = 2;
  localparam int FCS_READY_BIT = 1;
  localparam int FCS_FINE_BIT = 0;
  // field positions in the source register
  localparam int FCS_SRC_LSB = 0;
  localparam int FCS_REFSEL_BIT = 2;
  // reset values
  localparam logic [7:0] FCS_DIV_OSC_RST = 8'h40;
  localparam logic [7:0] FCS_TRIM_DEBUG_RST = 8'h80;
  localparam logic [1:0] FCS_BAND_RST = 2'h0;
  localparam logic [1:0] FCS_SRC_RST = 2'h0;
  // codes
  localparam logic [1:0] FCS_CODE_FLL = 2'h0;
  localparam logic [1:0] FCS_CODE_INT = 2'h1;
  localparam logic [1:0] FCS_CODE_EXT = 2'h2;
  localparam logic [1:0] FCS_CODE_RSVD = 2'h3;
  // fll multiplication factors
  localparam logic [10:0] FCS_FAC_LOW = 11'h200;
  localparam logic [10:0] FCS_FAC_MID = 11'h400;
  localparam logic [10:0] FCS_FAC_HIGH = 11'h600;
  localparam logic [10:0] FCS_FAC_LOW_MAX = 11'h260;
  localparam logic [10:0] FCS_FAC_MID_MAX = 11'h4c0;
  localparam logic [10:0] FCS_FAC_HIGH_MAX = 11'h720;
  // synchroniser depth and divider width
  localparam int FCS_SYNC_STAGES = 2;
  localparam int FCS_DIV_CNT_W = 3;
  // stop tracking states
  typedef enum logic [1:0] {FCS_RUN, FCS_STOP_KEEP, FCS_STOP_OFF} fcs_stop_type;
endpackage

// ### hdl/fcs_clock_config.sv
// control, trim and status registers of the internal clock generator
// assumes apb from a 10 MHz master, source ticks and reference level sampled on clock
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module fcs_clock_config
  import fcs_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // chip side
  input wire logic background_debug_mode,
  input wire logic stop_mode,
  input wire logic [7:0] factory_trim,
  input wire logic factory_fine_trim,
  input wire logic osc_startup_done,
  input wire logic src_clock_tick,
  input wire logic oscillator_output,
  // oscillator and clock consumers
  output logic osc_band_high,
  output logic osc_gain_high,
  output logic osc_crystal_req,
  output logic osc_enable,
  output logic fll_enable,
  output logic ext_ref_clock_out,
  output logic bus_clock_tick,
  output logic [8:0] ref_period_code,
  output logic [10:0] fll_factor,
  output logic [1:0] dco_band_active
);

  // maps a band and the max option onto the fll multiplier
  function automatic logic [10:0] fcs_factor(input logic [1:0] band, input logic dmx);
    logic [10:0] f;
    f = dmx ? FCS_FAC_LOW_MAX : FCS_FAC_LOW;
    case (band)
      FCS_CODE_FLL: f = dmx ? FCS_FAC_LOW_MAX : FCS_FAC_LOW;
      FCS_CODE_INT: f = dmx ? FCS_FAC_MID_MAX : FCS_FAC_MID;
      FCS_CODE_EXT: f = dmx ? FCS_FAC_HIGH_MAX : FCS_FAC_HIGH;
      default: f = dmx ? FCS_FAC_LOW_MAX : FCS_FAC_LOW;
    endcase
    return f;
  endfunction

  // folds the reserved source code onto the fll code
  function automatic logic [1:0] fcs_src_code(input logic [1:0] code);
    return (code == FCS_CODE_RSVD) ? FCS_CODE_FLL : code;
  endfunction

  // software visible state
  logic [7:0] div_osc_r; // divider and oscillator controls
  logic [7:0] trim_r; // coarse period trim
  logic fine_r; // fine period trim
  logic dmx_r; // maximum frequency option
  logic [1:0] band_sel_r; // requested dco band
  logic [1:0] src_sel_r; // clock source select
  logic ref_sel_r; // reference select, 1 = internal
  logic ready_r; // oscillator ready flag
  // two-stage synchronisers, first stage read only by second
  logic [1:0] band_s1_r;
  logic [1:0] band_st_r;
  logic [1:0] mode_s1_r;
  logic [1:0] mode_st_r;
  logic ref_s1_r;
  logic ref_st_r;
  // stop tracking
  fcs_stop_type stop_r;
  // bus divider
  logic [FCS_DIV_CNT_W-1:0] div_cnt_r;
  logic [FCS_DIV_CNT_W-1:0] div_mask;
  // output flops
  logic [31:0] prdata_r;
  logic eref_out_r;

  // field views
  logic [1:0] bus_clock_divider;
  logic fll_low_power;
  logic ext_source_select;
  logic ext_ref_enable;
  logic ext_ref_stop_enable;
  assign bus_clock_divider = div_osc_r[FCS_DIV_LSB+:2];
  assign fll_low_power = div_osc_r[FCS_LP_BIT];
  assign ext_source_select = div_osc_r[FCS_EREF_SEL_BIT];
  assign ext_ref_enable = div_osc_r[FCS_EREF_EN_BIT];
  assign ext_ref_stop_enable = div_osc_r[FCS_EREF_STOP_BIT];

  // bus decode
  logic setup_ph;
  logic wr_en;
  logic mapped;
  assign setup_ph = psel && !penable;
  assign mapped = (paddr == FCS_ADDR_DIV_OSC) || (paddr == FCS_ADDR_TRIM) ||
                  (paddr == FCS_ADDR_STATUS) || (paddr == FCS_ADDR_SOURCE);
  // zero wait states: read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wr_en = psel && penable && pwrite && mapped;
  assign prdata = prdata_r;

  // write of each register
  logic wr_div;
  logic wr_trim;
  logic wr_stat;
  logic wr_src;
  assign wr_div = wr_en && (paddr == FCS_ADDR_DIV_OSC);
  assign wr_trim = wr_en && (paddr == FCS_ADDR_TRIM);
  assign wr_stat = wr_en && (paddr == FCS_ADDR_STATUS);
  assign wr_src = wr_en && (paddr == FCS_ADDR_SOURCE);

  // effective mode codes; external use decides the oscillator
  logic ext_mode;
  logic bypassed;
  logic ext_in_use;
  assign ext_mode = !ref_st_r || (mode_st_r == FCS_CODE_EXT);
  assign bypassed = (mode_st_r == FCS_CODE_INT) || (mode_st_r == FCS_CODE_EXT);
  assign ext_in_use = ext_ref_enable || ext_mode;

  // divider and oscillator register, reset to divide by two
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      div_osc_r <= FCS_DIV_OSC_RST; // [R1]
    end else if (wr_div) begin
      div_osc_r <= pwdata[7:0];
    end
  end

  // trim fields load from factory unless debugging at reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      trim_r <= background_debug_mode ? FCS_TRIM_DEBUG_RST : factory_trim; // [R8]
      fine_r <= background_debug_mode ? 1'b0 : factory_fine_trim; // [R10]
    end else begin
      if (wr_trim) begin
        trim_r <= pwdata[7:0];
      end
      if (wr_stat) begin
        fine_r <= pwdata[FCS_FINE_BIT];
      end
    end
  end

  // band select and max option; a locked or reserved write keeps the band
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      band_sel_r <= FCS_BAND_RST;
      dmx_r <= 1'b0;
    end else if (wr_stat) begin
      dmx_r <= pwdata[FCS_DMX_BIT];
      // low power locks the band; the reserved code is dropped
      if (!fll_low_power && (pwdata[FCS_BAND_LSB+:2] != FCS_CODE_RSVD)) begin // [R13] [R14]
        band_sel_r <= pwdata[FCS_BAND_LSB+:2];
      end
    end
  end

  // source and reference select, fei after reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      src_sel_r <= FCS_SRC_RST;
      ref_sel_r <= 1'b1;
    end else if (wr_src) begin
      src_sel_r <= fcs_src_code(pwdata[FCS_SRC_LSB+:2]); // [R21]
      ref_sel_r <= pwdata[FCS_REFSEL_BIT];
    end
  end

  // status synchronisers: status reads never see a select the clock tree has not taken; the source register reads the raw selects
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      band_s1_r <= FCS_BAND_RST;
      band_st_r <= FCS_BAND_RST;
      mode_s1_r <= FCS_CODE_FLL;
      mode_st_r <= FCS_CODE_FLL;
      ref_s1_r <= 1'b1;
      ref_st_r <= 1'b1;
    end else begin
      band_s1_r <= band_sel_r; // [R22]
      band_st_r <= band_s1_r; // [R12]
      mode_s1_r <= src_sel_r;
      mode_st_r <= mode_s1_r; // [R18]
      ref_s1_r <= ref_sel_r;
      ref_st_r <= ref_s1_r; // [R17]
    end
  end

  // oscillator ready flag; a start-up in the clearing cycle still sets it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ready_r <= 1'b0;
    end else if (ext_in_use && ext_source_select && osc_startup_done) begin
      ready_r <= 1'b1; // [R19]
    end else if (!ext_ref_enable || !ext_source_select) begin
      // a direct clock input has no start-up, so the flag drops
      ready_r <= 1'b0; // [R20]
    end
  end

  // stop tracking: the keep decision is made at stop entry only
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stop_r <= FCS_RUN;
    end else begin
      case (stop_r)
        FCS_RUN: begin
          if (stop_mode) begin
            stop_r <= (ext_ref_enable && ext_ref_stop_enable) ? FCS_STOP_KEEP : FCS_STOP_OFF; // [R7]
          end
        end
        FCS_STOP_KEEP, FCS_STOP_OFF: begin
          if (!stop_mode) begin
            stop_r <= FCS_RUN;
          end
        end
        default: stop_r <= FCS_RUN;
      endcase
    end
  end

  // oscillator runs in run mode when used, in stop only if kept
  always_comb begin
    case (stop_r)
      FCS_RUN: osc_enable = ext_in_use && !stop_mode;
      FCS_STOP_KEEP: osc_enable = 1'b1; // [R7]
      FCS_STOP_OFF: osc_enable = 1'b0;
      default: osc_enable = 1'b0;
    endcase
  end

  // reference clock output follows the oscillator only while enabled
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      eref_out_r <= 1'b0;
    end else begin
      eref_out_r <= ext_ref_enable && osc_enable && oscillator_output; // [R6]
    end
  end
  assign ext_ref_clock_out = eref_out_r;

  // fll off in stop, and in bypass with low power unless debugging
  assign fll_enable = !stop_mode && !(fll_low_power && bypassed && !background_debug_mode); // [R4]

  // oscillator controls straight from the register
  assign osc_band_high = div_osc_r[FCS_BAND_BIT]; // [R2]
  assign osc_gain_high = div_osc_r[FCS_GAIN_BIT]; // [R3]
  assign osc_crystal_req = ext_source_select; // [R5]

  // one bus tick per 1, 2, 4 or 8 source ticks
  always_comb begin
    case (bus_clock_divider)
      2'h0: div_mask = 3'h0;
      2'h1: div_mask = 3'h1;
      2'h2: div_mask = 3'h3;
      2'h3: div_mask = 3'h7;
      default: div_mask = 3'h0;
    endcase
  end

  // divider count; the compare is masked too, so a new divider acts at once
  // and a stale count left by a wider divider cannot swallow a tick
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      div_cnt_r <= '0;
    end else if (src_clock_tick) begin
      div_cnt_r <= (div_cnt_r + 3'h1) & div_mask; // [R1]
    end
  end
  assign bus_clock_tick = src_clock_tick && ((div_cnt_r & div_mask) == 3'h0); // [R1]

  // combined period code: larger means a longer period, fine bit is the lsb
  assign ref_period_code = {trim_r, fine_r}; // [R9] [R11]
  // the factor follows the band the dco really runs in
  assign fll_factor = fcs_factor(band_st_r, dmx_r); // [R15] [R16]
  assign dco_band_active = band_st_r;

  // read data captured in the setup cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prdata_r <= '0;
    end else if (setup_ph && !pwrite) begin
      case (paddr)
        FCS_ADDR_DIV_OSC: prdata_r <= {24'h0, div_osc_r};
        FCS_ADDR_TRIM: prdata_r <= {24'h0, trim_r};
        FCS_ADDR_STATUS: prdata_r <= {24'h0, band_st_r, dmx_r, ref_st_r, mode_st_r, ready_r, fine_r};
        FCS_ADDR_SOURCE: prdata_r <= {29'h0, ref_sel_r, src_sel_r};
        default: prdata_r <= '0; // unmapped reads return zero
      endcase
    end
  end

  // checks
  default clocking fcs_cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // a band write shows in status two cycles after the select changes
  sequence band_change;
    band_sel_r != $past(band_sel_r);
  endsequence
  chk_band_status_delay: assert property (band_change |-> ##2 band_st_r == $past(band_sel_r, 2)) // [R12]
    else $error("band status did not follow select after two cycles");
  chk_band_locked_lp: assert property ((wr_stat && fll_low_power) |=> $stable(band_sel_r)) // [R14]
    else $error("band changed while low power set");
  chk_band_no_rsvd: assert property (wr_stat && pwdata[7:6] == 2'h3 |=> $stable(band_sel_r)) // [R13]
    else $error("reserved band code was taken");
  chk_mode_status_sync: assert property (1'b1 |-> ##2 mode_st_r == $past(src_sel_r, 2)) // [R18]
    else $error("mode status not two cycles behind select");
  chk_ref_status_sync: assert property ($rose(ref_sel_r) |-> !ref_st_r ##2 ref_st_r) // [R17]
    else $error("reference status changed at wrong time");
  chk_src_no_rsvd: assert property (src_sel_r != FCS_CODE_RSVD) // [R21]
    else $error("reserved source code stored");
  chk_eref_gated: assert property (!ext_ref_enable |=> !ext_ref_clock_out) // [R6]
    else $error("reference output active while disabled");
  chk_ready_set: assert property ((ext_in_use && ext_source_select && osc_startup_done) |=> ready_r) // [R19]
    else $error("ready flag not set after start-up");
  chk_ready_clear: assert property ((!ext_source_select) |=> !ready_r) // [R20]
    else $error("ready flag held with source select clear");
  chk_fll_lp_off: assert property ((fll_low_power && bypassed && !background_debug_mode) |-> !fll_enable) // [R4]
    else $error("fll enabled in low power bypass");
  chk_stop_keep: assert property ((stop_r == FCS_RUN && stop_mode && !(ext_ref_enable && ext_ref_stop_enable)) |=> !osc_enable) // [R7]
    else $error("oscillator kept in stop without both enables");
  chk_bus_div_one: assert property ((bus_clock_divider == 2'h0 && $past(bus_clock_divider) == 2'h0 && src_clock_tick) |-> bus_clock_tick) // [R1]
    else $error("divide by one missed a tick");
  chk_factor_max: assert property ((dmx_r && band_st_r == FCS_CODE_EXT) |-> fll_factor == 11'h720) // [R16]
    else $error("wrong high band max factor");
  chk_factor_def: assert property ((!dmx_r && band_st_r == FCS_CODE_INT) |-> fll_factor == 11'h400) // [R15]
    else $error("wrong mid band default factor");
  chk_factor_low_def: assert property ((!dmx_r && band_st_r == FCS_CODE_FLL) |-> fll_factor == 11'h200) // [R15]
    else $error("wrong low band default factor");
  chk_factor_high_def: assert property ((!dmx_r && band_st_r == FCS_CODE_EXT) |-> fll_factor == 11'h600) // [R15]
    else $error("wrong high band default factor");
  chk_factor_low_max: assert property ((dmx_r && band_st_r == FCS_CODE_FLL) |-> fll_factor == 11'h260) // [R16]
    else $error("wrong low band max factor");
  chk_factor_mid_max: assert property ((dmx_r && band_st_r == FCS_CODE_INT) |-> fll_factor == 11'h4c0) // [R16]
    else $error("wrong mid band max factor");

  // register writes land at the access edge and show one cycle later
  chk_div_write: assert property (wr_div |=> div_osc_r == $past(pwdata[7:0])) // [R1]
    else $error("divider register write lost");
  chk_trim_write: assert property (wr_trim |=> trim_r == $past(pwdata[7:0])) // [R9]
    else $error("coarse trim write lost");
  chk_fine_write: assert property (wr_stat |=> fine_r == $past(pwdata[FCS_FINE_BIT])) // [R11]
    else $error("fine trim write lost");
  chk_dmx_write: assert property (wr_stat |=> dmx_r == $past(pwdata[FCS_DMX_BIT])) // [R16]
    else $error("max option write lost");
  // an unlocked, non-reserved band code must be taken, or the lock checks prove nothing
  chk_band_taken: assert property ((wr_stat && !fll_low_power && pwdata[7:6] != FCS_CODE_RSVD)
    |=> band_sel_r == $past(pwdata[7:6])) // [R14]
    else $error("legal band write not taken");
  chk_src_fold: assert property ((wr_src && pwdata[1:0] == FCS_CODE_RSVD) |=> src_sel_r == FCS_CODE_FLL) // [R21]
    else $error("reserved source code not folded to fll");
  chk_ref_status_fall: assert property ($fell(ref_sel_r) |-> ##2 !ref_st_r) // [R17]
    else $error("reference status did not follow external select");

  // stop entry with both enables has the oscillator on again in the cycle after entry
  sequence stop_entry_keep;
    stop_r == FCS_RUN && stop_mode && ext_ref_enable && ext_ref_stop_enable;
  endsequence
  chk_stop_kept: assert property (stop_entry_keep |=> osc_enable) // [R7]
    else $error("oscillator dropped in stop with both enables");
  chk_stop_off_out: assert property ((stop_r == FCS_STOP_OFF) |=> !ext_ref_clock_out) // [R7]
    else $error("reference output active in stop without keep");
  // debugging overrides the low power gate outside stop
  chk_fll_debug_on: assert property ((background_debug_mode && !stop_mode) |-> fll_enable) // [R4]
    else $error("fll disabled while debugging");

endmodule
`default_nettype wire

// ### verification/fcs_osc_model.sv
// stand-in for the oscillator and the selected source clock
// assumes one clock; start-up ends a fixed count after a crystal is requested and enabled
`timescale 1ns/1ps
`default_nettype none
module fcs_osc_model #(
  parameter int STARTUP = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic osc_enable,
  input wire logic osc_crystal_req,
  output var logic oscillator_output,
  output var logic osc_startup_done,
  output var logic src_clock_tick
);
  int cnt; // start-up cycles seen so far
  // runs free even when disabled, so any leak past the design's gate shows
  always @(posedge clock) begin
    if (!rst_n) begin
      oscillator_output <= 1'b0;
      src_clock_tick <= 1'b0;
    end else begin
      oscillator_output <= ~oscillator_output;
      src_clock_tick <= ~src_clock_tick; // one source tick every second cycle
    end
  end
  // start-up count only runs while a crystal is requested and enabled
  always @(posedge clock) begin
    if (!rst_n || !(osc_enable && osc_crystal_req)) begin
      cnt <= 0;
      osc_startup_done <= 1'b0;
    end else begin
      if (cnt < STARTUP) cnt <= cnt + 1;
      osc_startup_done <= (cnt >= STARTUP);
    end
  end
endmodule
`default_nettype wire

// ### verification/fcs_clock_config_test.sv
// self-checking bench of the clock configuration block over apb
// assumes the oscillator model on the far side and a 10 MHz clock
`timescale 1ns/1ps
`default_nettype none
module fcs_clock_config_test import fcs_pkg::*; ;
  logic clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err_seen, debug = 1'b0, stop = 1'b0;
  logic osc_out, start_done, src_tick, band_hi, gain_hi, crys, osc_en, fll_en, ext_out, bus_tick;
  logic [8:0] ref_code;
  logic [10:0] factor;
  logic [1:0] band_act;
  int errors = 0, cmp_count = 0, cycles = 0, n;
  fcs_clock_config dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .background_debug_mode(debug), .stop_mode(stop),
    .factory_trim(8'h5a), .factory_fine_trim(1'b1), .osc_startup_done(start_done),
    .src_clock_tick(src_tick), .oscillator_output(osc_out), .osc_band_high(band_hi),
    .osc_gain_high(gain_hi), .osc_crystal_req(crys), .osc_enable(osc_en),
    .fll_enable(fll_en), .ext_ref_clock_out(ext_out), .bus_clock_tick(bus_tick),
    .ref_period_code(ref_code), .fll_factor(factor), .dco_band_active(band_act));
  fcs_osc_model model (.clock(clock), .rst_n(rst_n), .osc_enable(osc_en),
    .osc_crystal_req(crys), .oscillator_output(osc_out), .osc_startup_done(start_done),
    .src_clock_tick(src_tick));
  initial begin
    forever #50 clock = ~clock;
  end
  // hang guard, far above the roughly 700 cycles the tests need
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer; answer is taken at the edge that sees pready high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    chk(what, exp, rd);
  endtask
  task automatic do_reset(input logic dbg);
    @(posedge clock);
    debug <= dbg;
    rst_n <= 1'b0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
  endtask
  // counts changes of the reference clock output over 40 cycles
  task automatic toggles(output int t);
    logic last;
    t = 0;
    last = ext_out;
    repeat (40) begin
      @(posedge clock);
      if (ext_out !== last) t++;
      last = ext_out;
    end
  endtask
  function automatic logic [10:0] fac(input int b, input int m);
    logic [10:0] t[6] = '{11'h200, 11'h260, 11'h400, 11'h4c0, 11'h600, 11'h720};
    return t[b * 2 + m];
  endfunction
  initial begin
    do_reset(1'b0);
    rd_chk("div_osc", FCS_ADDR_DIV_OSC, 32'h40);
    rd_chk("trim", FCS_ADDR_TRIM, 32'h5a);
    rd_chk("status", FCS_ADDR_STATUS, 32'h11);
    rd_chk("unmapped", 8'h10, 32'h0);
    chk("slverr", 32'h1, {31'h0, err_seen});
    apb(1'b1, FCS_ADDR_TRIM, 8'ha5);
    rd_chk("trim_rw", FCS_ADDR_TRIM, 32'ha5);
    chk("period", 32'h14b, {23'h0, ref_code});
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, FCS_ADDR_DIV_OSC, 8'(c << 6));
      repeat (20) @(posedge clock);
      n = 0;
      repeat (64) begin
        @(posedge clock);
        if (bus_tick === 1'b1) n++;
      end
      chk("bus_ticks", 32 >> c, n);
    end
    // every band and option pair; status lags the select by the synchroniser
    for (int b = 0; b < 3; b++) begin
      for (int m = 0; m < 2; m++) begin
        apb(1'b1, FCS_ADDR_STATUS, 8'((b << 6) | (m << 5)));
        @(posedge clock);
        chk("band_lag", (m == 0) ? b - 1 + (b == 0) : b, band_act);
        repeat (2) @(posedge clock);
        chk("factor", fac(b, m), factor);
        rd_chk("band_st", FCS_ADDR_STATUS, 32'((b << 6) | (m << 5) | 8'h10));
      end
    end
    apb(1'b1, FCS_ADDR_STATUS, 8'hc0);
    rd_chk("band_rsvd", FCS_ADDR_STATUS, 32'h90);
    apb(1'b1, FCS_ADDR_DIV_OSC, 8'h08);
    apb(1'b1, FCS_ADDR_STATUS, 8'h00);
    rd_chk("band_lp", FCS_ADDR_STATUS, 32'h90);
    apb(1'b1, FCS_ADDR_SOURCE, 8'h05);
    repeat (3) @(posedge clock);
    chk("fll_lp", 32'h0, {31'h0, fll_en});
    rd_chk("mode_int", FCS_ADDR_STATUS, 32'h94);
    apb(1'b1, FCS_ADDR_DIV_OSC, 8'h00);
    repeat (3) @(posedge clock);
    chk("fll_on", 32'h1, {31'h0, fll_en});
    // the read setup edge comes after the second stage takes the new select
    apb(1'b1, FCS_ADDR_SOURCE, 8'h02);
    repeat (2) @(posedge clock);
    rd_chk("mode_ext", FCS_ADDR_STATUS, 32'h88);
    apb(1'b1, FCS_ADDR_SOURCE, 8'h07);
    repeat (2) @(posedge clock);
    rd_chk("mode_rsvd", FCS_ADDR_STATUS, 32'h90);
    apb(1'b1, FCS_ADDR_DIV_OSC, 8'h30);
    toggles(n);
    chk("ref_off", 32'h0, n);
    chk("osc_bits", 32'h6, {29'h0, band_hi, gain_hi, crys});
    apb(1'b1, FCS_ADDR_DIV_OSC, 8'h36);
    repeat (30) @(posedge clock);
    rd_chk("ready_set", FCS_ADDR_STATUS, 32'h92);
    toggles(n);
    chk("ref_on", 32'h1, 32'(n > 10));
    apb(1'b1, FCS_ADDR_DIV_OSC, 8'h37);
    stop <= 1'b1;
    toggles(n);
    chk("stop_keep", 32'h1, 32'(n > 10));
    stop <= 1'b0;
    apb(1'b1, FCS_ADDR_DIV_OSC, 8'h36);
    stop <= 1'b1;
    repeat (3) @(posedge clock);
    toggles(n);
    chk("stop_off", 32'h0, n);
    chk("osc_off", 32'h0, {31'h0, osc_en});
    stop <= 1'b0;
    apb(1'b1, FCS_ADDR_DIV_OSC, 8'h34);
    rd_chk("ready_clr", FCS_ADDR_STATUS, 32'h90);
    apb(1'b1, FCS_ADDR_DIV_OSC, 8'h32);
    @(posedge clock);
    chk("crystal", 32'h0, {31'h0, crys});
    do_reset(1'b1);
    rd_chk("trim_dbg", FCS_ADDR_TRIM, 32'h80);
    rd_chk("fine_dbg", FCS_ADDR_STATUS, 32'h10);
    stop_test();
  end
endmodule
`default_nettype wire
